// ===== stk_pkg.sv
// constants and types for the single touch key output logic
// Function
// - polarity low: output active high, reads 0 from power-on until touch.
// - polarity high: output active low, reads 0 in reset, 1 from the third clock after reset until touch.
// - direct mode follows touch; latched mode toggles on each touch.
// - touch held past 13 s recalibrates and restores the power-on output.
// - capture reference at end of settle, keep tracking it while untouched.
// - touch enters normal mode; 4 s without touch returns to standby.
// - output responds 48 ms after touch in normal, 160 ms in standby.
// - 0.3 s settle interval after power-on; touches then are ignored.
package stk_pkg;
  localparam longint unsigned CLK_HZ        = 100_000_000;
  localparam longint unsigned HOLD_MAX_MS   = 13_000;
  localparam longint unsigned IDLE_MS       = 4_000;
  localparam longint unsigned RESP_NORM_MS  = 48;
  localparam longint unsigned RESP_STBY_MS  = 160;
  localparam longint unsigned SETTLE_MS     = 300;
  localparam longint unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam longint unsigned HOLD_MAX_CYC  = HOLD_MAX_MS * CYC_PER_MS;
  localparam longint unsigned IDLE_CYC      = IDLE_MS * CYC_PER_MS;
  localparam longint unsigned RESP_NORM_CYC = RESP_NORM_MS * CYC_PER_MS;
  localparam longint unsigned RESP_STBY_CYC = RESP_STBY_MS * CYC_PER_MS;
  localparam longint unsigned SETTLE_CYC    = SETTLE_MS * CYC_PER_MS;
  localparam int              CNT_W         = 32;
  localparam logic [15:0]     REF_RESET     = 16'h0000;
  typedef enum logic [1:0] {STK_SETTLE, STK_IDLE, STK_DEBOUNCE, STK_HELD}
    stk_state_e;
endpackage : stk_pkg

// ===== stk_touch_key.sv
// touch key output logic: polarity, direct/latched, timeouts, reference
`timescale 1ns/1ps
`default_nettype none
module stk_touch_key
  import stk_pkg::*;
#(
  parameter logic [CNT_W-1:0] SETTLE_C    = CNT_W'(SETTLE_CYC),
  parameter logic [CNT_W-1:0] RESP_NORM_C = CNT_W'(RESP_NORM_CYC),
  parameter logic [CNT_W-1:0] RESP_STBY_C = CNT_W'(RESP_STBY_CYC),
  parameter logic [CNT_W-1:0] IDLE_C      = CNT_W'(IDLE_CYC),
  parameter logic [CNT_W-1:0] HOLD_MAX_C  = CNT_W'(HOLD_MAX_CYC),
  parameter int               REF_W       = 16
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             polarity_select_i,
  input  wire logic             latched_mode_i,
  input  wire logic             touch_sense_input_i,
  input  wire logic [REF_W-1:0] sense_level_i,
  output logic                  output_bit_o,
  output logic                  standby_o,
  output logic [REF_W-1:0]      reference_o
);
  // every check below runs on this clock and is muted in reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // polarity, mode and touch pins cross in through two flops; sense_level_i does not
  logic [1:0] pol_sync_q, touch_sync_q, mode_sync_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pol_sync_q   <= 2'h0;
      touch_sync_q <= 2'h0;
      mode_sync_q  <= 2'h0;
    end else begin
      pol_sync_q   <= {pol_sync_q[0], polarity_select_i};
      touch_sync_q <= {touch_sync_q[0], touch_sense_input_i};
      mode_sync_q  <= {mode_sync_q[0], latched_mode_i};
    end
  end
  logic touch, latched;
  assign touch   = touch_sync_q[1];
  assign latched = mode_sync_q[1];

  stk_state_e       state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, idle_q, idle_d;
  logic             active_q, active_d, stby_q, stby_d, pol_q, pol_d;
  logic             out_q, out_d, ref_load_q, ref_load_d;
  // set by a timeout, so a covered pad cannot fire again at once
  logic             stuck_q, stuck_d;
  logic [REF_W-1:0] ref_q, ref_d;
  logic [CNT_W-1:0] resp_c;

  // response wait depends on mode at moment of touch
  assign resp_c = stby_q ? RESP_STBY_C : RESP_NORM_C;

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    idle_d     = idle_q;
    active_d   = active_q;
    stby_d     = stby_q;
    pol_d      = pol_q;
    ref_load_d = 1'b0;
    stuck_d    = stuck_q;
    unique case (state_q)
      STK_SETTLE: begin
        // polarity caught at end of settle, after sync flops are valid
        pol_d = pol_sync_q[1];
        if (cnt_q >= SETTLE_C - 1) begin
          state_d    = STK_IDLE;
          cnt_d      = '0;
          ref_load_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      STK_IDLE: begin
        // a recalibrated pad counts again only after release
        if (!touch) stuck_d = 1'b0;
        if (touch && !stuck_q) begin
          state_d = STK_DEBOUNCE;
          cnt_d   = '0;
        end else if (idle_q >= IDLE_C - 1) begin
          stby_d = 1'b1;
        end else begin
          idle_d = idle_q + 1'b1;
        end
      end
      STK_DEBOUNCE: begin
        if (!touch) begin
          state_d = STK_IDLE;
        end else if (cnt_q >= resp_c - 1) begin
          state_d  = STK_HELD;
          cnt_d    = '0;
          stby_d   = 1'b0;
          idle_d   = '0;
          active_d = latched ? !active_q : 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      STK_HELD: begin
        idle_d = '0;
        if (!touch) begin
          state_d = STK_IDLE;
          if (!latched) active_d = 1'b0;
        end else if (cnt_q >= HOLD_MAX_C - 1) begin
          state_d    = STK_IDLE;
          active_d   = 1'b0;
          stuck_d    = 1'b1;
          ref_load_d = 1'b1;
          cnt_d      = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
    endcase
    // polarity frozen after settle, so the idle level never moves
    out_d = active_d ^ pol_d;
  end

  // reference tracks slowly while untouched; reload on capture
  always_comb begin
    ref_d = ref_q;
    if (ref_load_q) ref_d = sense_level_i;
    else if (state_q == STK_IDLE && !touch) begin
      if (sense_level_i > ref_q) ref_d = ref_q + 1'b1;
      else if (sense_level_i < ref_q) ref_d = ref_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q    <= STK_SETTLE;
      cnt_q      <= '0;
      idle_q     <= '0;
      active_q   <= 1'b0;
      stby_q     <= 1'b1;
      pol_q      <= 1'b0;
      out_q      <= 1'b0;
      ref_load_q <= 1'b0;
      stuck_q    <= 1'b0;
      ref_q      <= REF_RESET[REF_W-1:0];
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      idle_q     <= idle_d;
      active_q   <= active_d;
      stby_q     <= stby_d;
      pol_q      <= pol_d;
      out_q      <= out_d;
      ref_load_q <= ref_load_d;
      stuck_q    <= stuck_d;
      ref_q      <= ref_d;
    end
  end

  assign output_bit_o = out_q;
  assign standby_o    = stby_q;
  assign reference_o  = ref_q;

  a_out_polarity: assert property (
    state_q != STK_SETTLE && !active_q |-> output_bit_o == pol_q)
    else $error("idle output level wrong");
  a_out_active_low: assert property (
    pol_q && active_q |-> !output_bit_o)
    else $error("active low output wrong");
  a_pol_fixed: assert property (
    state_q != STK_SETTLE |=> $stable(pol_q))
    else $error("polarity moved after settle");
  a_direct_press: assert property (
    state_q == STK_DEBOUNCE && state_d == STK_HELD && !latched |=> active_q)
    else $error("direct output not asserted");
  a_direct_release: assert property (
    state_q == STK_HELD && !touch && !latched |=> !active_q)
    else $error("direct output not released");
  a_latch_toggle: assert property (
    state_q == STK_DEBOUNCE && state_d == STK_HELD && latched
    |=> active_q != $past(active_q))
    else $error("latched output did not toggle");
  a_hold_timeout: assert property (
    state_q == STK_HELD && touch && cnt_q >= HOLD_MAX_C - 1
    |=> !active_q && stuck_q ##1 ref_q == $past(sense_level_i))
    else $error("stuck key not recalibrated");
  a_stuck_wait: assert property (
    state_q == STK_IDLE && stuck_q && touch |=> state_q == STK_IDLE)
    else $error("stuck key counted again");
  a_idle_standby: assert property (
    state_q == STK_IDLE && !touch && idle_q >= IDLE_C - 1 |=> stby_q)
    else $error("standby not entered");
  a_touch_wakes: assert property (
    state_q == STK_DEBOUNCE && state_d == STK_HELD |=> !standby_o)
    else $error("touch did not leave standby");
  a_resp_delay: assert property (
    state_q == STK_HELD && $past(state_q) == STK_DEBOUNCE
    |-> $past(cnt_q) == $past(resp_c) - 1)
    else $error("response delay wrong");
  a_settle_quiet: assert property (
    state_q == STK_SETTLE |-> !active_q)
    else $error("touch reported while settling");
  a_ref_track: assert property (
    state_q == STK_IDLE && !touch && !ref_load_q
    && sense_level_i > ref_q && !(&ref_q) |=> ref_q == $past(ref_q) + 1'b1)
    else $error("reference not tracking");
  a_ref_track_dn: assert property (
    state_q == STK_IDLE && !touch && !ref_load_q
    && sense_level_i < ref_q |=> ref_q == $past(ref_q) - 1'b1)
    else $error("reference not tracking down");

  // main scenarios: both wake speeds, timeout, latched release
  c_touch_normal: cover property (@(posedge clk_i)
    !stby_q && state_q == STK_DEBOUNCE ##1 state_q == STK_HELD);
  c_touch_stby: cover property (@(posedge clk_i)
    stby_q && state_q == STK_DEBOUNCE ##1 state_q == STK_HELD);
  c_timeout: cover property (@(posedge clk_i)
    state_q == STK_HELD ##1 ref_load_q);
  c_latch_off: cover property (@(posedge clk_i)
    latched && $fell(active_q));
  c_stuck_clear: cover property (@(posedge clk_i)
    state_q == STK_IDLE && stuck_q ##1 !stuck_q);
endmodule : stk_touch_key
`default_nettype wire

// ===== stk_host_model.sv
// host load counting edges on the key output
`timescale 1ns/1ps
`default_nettype none
module stk_host_model (
  input  wire logic       clk_i,
  input  wire logic       key_i,
  output var  logic [7:0] edges_o
);
  logic last_q = 1'b0;
  initial edges_o = 8'h00;
  always @(posedge clk_i) begin
    last_q <= key_i;
    if (last_q !== key_i) edges_o <= edges_o + 8'h01;
  end
endmodule // stk_host_model
`default_nettype wire

// ===== stk_touch_key_bench.sv
// self-checking bench for the touch key output logic
`timescale 1ns/1ps
`default_nettype none
module stk_touch_key_bench;
  import stk_pkg::*;
  logic        clk_i = 0, reset_i = 1, pol = 0, lat = 0, touch = 0, v;
  logic [15:0] lvl = 16'h0000, ref_w;
  logic        key, stby;
  logic [7:0]  edges, e0;
  int          bad_count = 0, checks = 0, cyc = 0, seed = 87, n;
  always #5 clk_i = ~clk_i;
  stk_touch_key #(.SETTLE_C(32'h0000_0014), .RESP_NORM_C(32'h0000_0005),
    .RESP_STBY_C(32'h0000_000A), .IDLE_C(32'h0000_0032),
    .HOLD_MAX_C(32'h0000_0064)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .polarity_select_i(pol), .latched_mode_i(lat),
    .touch_sense_input_i(touch), .sense_level_i(lvl), .output_bit_o(key),
    .standby_o(stby), .reference_o(ref_w));
  stk_host_model u_host (.clk_i(clk_i), .key_i(key), .edges_o(edges));
  // slack of 6 covers the input sync and output register
  function automatic logic lat_ok(int c, int resp);
    return c >= resp && c <= resp + 6;
  endfunction
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic press(int hold, output int c, output logic val);
    logic s;
    s = key;
    c = 0;
    touch <= 1;
    while (key === s && c < hold) begin
      tick(1);
      c++;
    end
    tick(hold - c);
    val = key;
    touch <= 0;
    tick(6);
  endtask
  task automatic do_reset(logic p, logic l);
    reset_i <= 1;
    pol <= p;
    lat <= l;
    tick(10);
    reset_i <= 0;
    tick(5);
    touch <= 1;
    tick(5);
    touch <= 0;
    tick(20);
    check("idle", key, p);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    do_reset(0, 0);
    check("stby", stby, 1);
    press(16, n, v);
    check("lat_s", lat_ok(n, 10), 1);
    check("held", v, 1);
    check("rel", key, 0);
    check("norm", stby, 0);
    press(12, n, v);
    check("lat_n", lat_ok(n, 5), 1);
    tick(60);
    check("stby2", stby, 1);
    lvl <= 16'($random(seed)) & 16'h003F;
    tick(80);
    check("track", ref_w, lvl);
    $display("test direct done");
    lvl <= 16'h0100 + (16'($random(seed)) & 16'h00FF);
    press(125, n, v);
    check("tmo", v, 0);
    check("reload", ref_w, lvl);
    lvl <= lvl - (16'($random(seed)) & 16'h001F) - 16'h0001;
    tick(40);
    check("track_dn", ref_w, lvl);
    e0 = edges;
    press(1 + ($random(seed) & 3), n, v);
    check("short", key, 0);
    check("short_e", 8'(edges - e0), 0);
    $display("test timeout done");
    do_reset(1, 1);
    e0 = edges;
    press(16, n, v);
    check("flip", v, 0);
    check("keep", key, 0);
    press(12, n, v);
    check("flip2", key, 1);
    check("edges", edges - e0, 2);
    $display("test latched done");
    summarize();
  end
endmodule // stk_touch_key_bench
`default_nettype wire
